// ==== design/nhsp_host_port.sv ====
// nibble host serial port: six-wire slave that reads and writes internal registers
// Behaviour
// - select addresses device; first byte is instruction
// - same operation codes as two-wire host port
// - 0x1x/0x2x write; incrementing variant advances pointer
// - 0x9x/0xAx read data follows address byte
// - select high ignores bus, edges init/clear
// - sample on clock fall, launch on rise
// - byte is two nibbles, upper first, unlimited
`timescale 1ns/100ps
`default_nettype none

module nhsp_host_port (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // host link pins
  input wire logic host_frame_select_n,
  input wire logic host_port_clk,
  input wire logic [nhsp_pkg::NIB_W-1:0] host_nibble_bus_in,
  output logic [nhsp_pkg::NIB_W-1:0] host_nibble_bus_out,
  output logic host_nibble_bus_oe_n,
  // internal register port
  output logic [nhsp_pkg::ADDR_W-1:0] reg_addr,
  output logic [nhsp_pkg::BYTE_W-1:0] reg_wdata,
  output logic reg_we,
  output logic reg_re,
  input wire logic [nhsp_pkg::BYTE_W-1:0] reg_rdata
);
  import nhsp_pkg::*;

  logic fs_s1_q, fs_s2_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic [NIB_W-1:0] dt_s1_q, dt_s2_q;
  logic frm_act, fall, rise, byte_done;
  logic nib_lo_q;
  logic [NIB_W-1:0] hi_nib_q;
  logic [BYTE_W-1:0] rx_byte;
  nhsp_state_t state_q;
  logic op_rd_q, op_inc_q, addr_hi_q;
  logic [ADDR_W-1:0] ptr_q, reg_addr_q;
  logic [BYTE_W-1:0] reg_wdata_q, tx_q;
  logic reg_we_q, reg_re_q, fetch_q;
  logic [NIB_W-1:0] nib_out_q;
  logic nib_oe_n_q;

  // two-stage synchronisers for all link pins, plus clock history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fs_s1_q <= 1'b1;
      fs_s2_q <= 1'b1;
      ck_s1_q <= 1'b1;
      ck_s2_q <= 1'b1;
      ck_s3_q <= 1'b1;
      dt_s1_q <= NIB_IDLE;
      dt_s2_q <= NIB_IDLE;
    end else begin
      fs_s1_q <= host_frame_select_n;
      fs_s2_q <= fs_s1_q;
      ck_s1_q <= host_port_clk;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= host_nibble_bus_in;
      dt_s2_q <= dt_s1_q;
    end
  end

  // frame and link clock edges; data is delayed alike so it lines up
  assign frm_act = !fs_s2_q;
  assign fall = ck_s3_q & !ck_s2_q;
  assign rise = !ck_s3_q & ck_s2_q;
  assign byte_done = frm_act & fall & nib_lo_q;
  assign rx_byte = {hi_nib_q, dt_s2_q};

  // nibble pairing, upper nibble first; a half byte dies with the frame
  always_ff @(posedge clk) begin
    if (!rst_n || !frm_act) begin
      nib_lo_q <= 1'b0;
      hi_nib_q <= NIB_IDLE;
    end else if (fall) begin
      nib_lo_q <= !nib_lo_q;
      if (!nib_lo_q) begin
        hi_nib_q <= dt_s2_q;
      end
    end
  end

  // transfer phase: instruction, address, then any number of data bytes
  always_ff @(posedge clk) begin
    if (!rst_n || !frm_act) begin
      state_q <= NHSP_INSTR;
    end else if (byte_done) begin
      unique case (state_q)
        NHSP_INSTR: begin
          // first byte is always the instruction, no device address
          unique case (rx_byte[BYTE_W-1:NIB_W])
            OP_WR_INC, OP_WR_FIX, OP_RD_INC, OP_RD_FIX: state_q <= NHSP_ADDR;
            default: state_q <= NHSP_IGNORE;
          endcase
        end
        NHSP_ADDR: state_q <= op_rd_q ? NHSP_RDATA : NHSP_WDATA;
        NHSP_WDATA, NHSP_RDATA, NHSP_IGNORE: state_q <= state_q;
      endcase
    end
  end

  // operation flags taken from the instruction byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_rd_q <= 1'b0;
      op_inc_q <= 1'b0;
      addr_hi_q <= 1'b0;
    end else if (byte_done && state_q == NHSP_INSTR) begin
      op_rd_q <= rx_byte[BYTE_W-1];
      op_inc_q <= (rx_byte[BYTE_W-1:NIB_W] == OP_WR_INC) ||
                  (rx_byte[BYTE_W-1:NIB_W] == OP_RD_INC);
      addr_hi_q <= rx_byte[INSTR_ADDR_BIT];
    end
  end

  // address pointer and internal register strobes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_q <= '0;
      reg_addr_q <= '0;
      reg_wdata_q <= '0;
      reg_we_q <= 1'b0;
      reg_re_q <= 1'b0;
    end else begin
      reg_we_q <= 1'b0;
      reg_re_q <= 1'b0;
      if (byte_done) begin
        unique case (state_q)
          NHSP_ADDR: begin
            ptr_q <= {addr_hi_q, rx_byte};
            if (op_rd_q) begin
              // fetch the first read byte at once so it can be launched next
              reg_re_q <= 1'b1;
              reg_addr_q <= {addr_hi_q, rx_byte};
              if (op_inc_q) begin
                ptr_q <= {addr_hi_q, rx_byte} + ADDR_W'(1);
              end
            end
          end
          NHSP_WDATA: begin
            reg_we_q <= 1'b1;
            reg_addr_q <= ptr_q;
            reg_wdata_q <= rx_byte;
            if (op_inc_q) begin
              ptr_q <= ptr_q + ADDR_W'(1);
            end
          end
          NHSP_RDATA: begin
            // byte clocked out: prefetch the next one
            reg_re_q <= 1'b1;
            reg_addr_q <= ptr_q;
            if (op_inc_q) begin
              ptr_q <= ptr_q + ADDR_W'(1);
            end
          end
          NHSP_INSTR, NHSP_IGNORE: begin
            ptr_q <= ptr_q;
          end
        endcase
      end
    end
  end

  // capture read data one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fetch_q <= 1'b0;
      tx_q <= '0;
    end else begin
      fetch_q <= reg_re_q;
      if (fetch_q) begin
        tx_q <= reg_rdata;
      end
    end
  end

  // nibble driver: launch on rising link clock, only in the read phase
  always_ff @(posedge clk) begin
    if (!rst_n || !frm_act) begin
      nib_oe_n_q <= 1'b1;
      nib_out_q <= NIB_IDLE;
    end else if (rise && state_q == NHSP_RDATA) begin
      nib_oe_n_q <= 1'b0;
      nib_out_q <= nib_lo_q ? tx_q[NIB_W-1:0] : tx_q[BYTE_W-1:NIB_W];
    end
  end

  assign host_nibble_bus_out = nib_out_q;
  assign host_nibble_bus_oe_n = nib_oe_n_q;
  assign reg_addr = reg_addr_q;
  assign reg_wdata = reg_wdata_q;
  assign reg_we = reg_we_q;
  assign reg_re = reg_re_q;

  // helper: address of the previous strobe within this frame
  logic [ADDR_W-1:0] last_addr_q;
  logic seen_q;
  always_ff @(posedge clk) begin
    if (!rst_n || !frm_act) begin
      seen_q <= 1'b0;
      last_addr_q <= '0;
    end else if (reg_we_q || reg_re_q) begin
      seen_q <= 1'b1;
      last_addr_q <= reg_addr_q;
    end
  end

  frame_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !frm_act |=> (host_nibble_bus_oe_n && !reg_we && !reg_re && state_q == NHSP_INSTR))
    else $error("port active while frame select is high");

  write_incr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_we && seen_q && op_inc_q) |-> reg_addr == last_addr_q + 1'b1)
    else $error("incrementing write did not advance the address");

  write_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_we && seen_q && !op_inc_q) |-> reg_addr == last_addr_q)
    else $error("fixed write moved the address");

  start_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (byte_done && state_q == NHSP_ADDR) |=> reg_addr_q == {addr_hi_q, $past(rx_byte)}
      || !op_rd_q)
    else $error("read did not start at the address byte");

  launch_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(host_nibble_bus_out) && frm_act) |-> $past(rise))
    else $error("nibble launched without a rising link clock");

  sample_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(nib_lo_q) && $past(frm_act) && frm_act) |-> $past(fall))
    else $error("nibble sampled without a falling link clock");

  drive_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(host_nibble_bus_oe_n) |-> state_q == NHSP_RDATA && op_rd_q)
    else $error("bus driven outside the read phase");

  first_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == NHSP_INSTR && byte_done) |=>
      (state_q == NHSP_ADDR || state_q == NHSP_IGNORE || !frm_act))
    else $error("instruction byte not taken as instruction");

  strobe_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_we || reg_re) |-> !nib_lo_q ##1 !(reg_we || reg_re))
    else $error("strobe not on a whole byte boundary");

  read_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_re |-> ##2 tx_q == $past(reg_rdata, 1))
    else $error("read data not captured after the strobe");

endmodule

`default_nettype wire

// ==== design/nhsp_pkg.sv ====
// constants and types shared by the nibble host serial port
package nhsp_pkg;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int ADDR_W = BYTE_W + 1;
  // upper nibble of the instruction byte selects the operation
  localparam logic [NIB_W-1:0] OP_WR_INC = 4'h1;
  localparam logic [NIB_W-1:0] OP_WR_FIX = 4'h2;
  localparam logic [NIB_W-1:0] OP_RD_INC = 4'h9;
  localparam logic [NIB_W-1:0] OP_RD_FIX = 4'ha;
  // instruction bit that carries the top register address bit
  localparam int INSTR_ADDR_BIT = 0;
  // level of the released bus (pull-ups)
  localparam logic [NIB_W-1:0] NIB_IDLE = 4'hf;
  typedef enum logic [2:0] {
    NHSP_INSTR,
    NHSP_ADDR,
    NHSP_WDATA,
    NHSP_RDATA,
    NHSP_IGNORE
  } nhsp_state_t;
endpackage

// ==== dv/nhsp_host_model.sv ====
// host controller model that frames and clocks the nibble link
`timescale 1ns/100ps
`default_nettype none
module nhsp_host_model (
  // system
  input wire logic clk,
  // link wires
  output logic frame_n,
  output logic lclk,
  output logic [3:0] wire_lvl,
  input wire logic [3:0] dev_out,
  input wire logic dev_oe_n
);
  logic drv = 1'b0;
  logic [3:0] dat = 4'hf;
  // wire level; pull-ups win when nobody drives
  assign wire_lvl = !dev_oe_n ? dev_out : (drv ? dat : 4'hf);
  initial begin
    frame_n = 1'b1;
    lclk = 1'b1;
  end
  // half of a 160 ns link period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // select low opens the frame, clock idle high
  task automatic start();
    frame_n = 1'b0;
    half();
  endtask
  task automatic stop();
    lclk = 1'b1;
    drv = 1'b0;
    half();
    frame_n = 1'b1;
    half();
  endtask
  // rise, present nibble, sample and fall
  task automatic nib(input logic rd, input logic [3:0] o, output logic [3:0] i);
    lclk = 1'b1;
    drv = !rd;
    dat = o;
    half();
    i = wire_lvl;
    lclk = 1'b0;
    half();
  endtask
  // upper nibble first
  task automatic xfer(input logic rd, input logic [7:0] o, output logic [7:0] i);
    nib(rd, o[7:4], i[7:4]);
    nib(rd, o[3:0], i[3:0]);
  endtask
  // clocking and data while deselected
  task automatic noise(input logic [3:0] d);
    drv = 1'b1;
    dat = d;
    repeat (4) begin
      lclk = ~lclk;
      half();
    end
    drv = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/nhsp_host_port_test.sv ====
// self-checking bench for the nibble host serial port
`timescale 1ns/100ps
`default_nettype none
module nhsp_host_port_test;
  import nhsp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fs_n, lclk, oe_n, we, re;
  logic [3:0] lvl, dout;
  logic [8:0] addr;
  logic [7:0] wdata, junk, a;
  logic [7:0] rdata = 8'h00;
  logic [7:0] mem [512];
  logic [16:0] exp_q [$];
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'hf312a628;
  nhsp_host_port dut_u (.clk(clk), .rst_n(rst_n), .host_frame_select_n(fs_n),
    .host_port_clk(lclk), .host_nibble_bus_in(lvl), .host_nibble_bus_out(dout),
    .host_nibble_bus_oe_n(oe_n), .reg_addr(addr), .reg_wdata(wdata), .reg_we(we),
    .reg_re(re), .reg_rdata(rdata));
  nhsp_host_model host_u (.clk(clk), .frame_n(fs_n), .lclk(lclk), .wire_lvl(lvl),
    .dev_out(dout), .dev_oe_n(oe_n));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [16:0] s, input logic [16:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // register file answers a read strobe at the falling clock edge inside the strobe cycle
  always @(negedge clk) begin
    if (re === 1'b1) rdata <= mem[addr];
  end
  // write strobes taken against the oldest expectation, away from the launching edge
  always @(negedge clk) begin
    if (rst_n && we === 1'b1) begin
      if (exp_q.size() == 0) check({addr, wdata}, 17'h1ffff);
      else check({addr, wdata}, exp_q.pop_front());
      mem[addr] <= wdata;
    end
  end
  task automatic wr(input logic [7:0] ins, input logic [7:0] ad, input int n);
    logic [7:0] d;
    logic [8:0] p;
    p = {ins[0], ad};
    host_u.start();
    host_u.xfer(1'b0, ins, junk);
    host_u.xfer(1'b0, ad, junk);
    repeat (n) begin
      d = 8'($random(seed));
      if (ins[7:4] == OP_WR_INC || ins[7:4] == OP_WR_FIX) exp_q.push_back({p, d});
      if (ins[7:4] == OP_WR_INC) p = p + 9'h1;
      host_u.xfer(1'b0, d, junk);
    end
    host_u.stop();
    check(17'(exp_q.size()), 17'h0);
  endtask
  task automatic rd(input logic [7:0] ins, input logic [7:0] ad, input int n);
    logic [7:0] got;
    logic [8:0] p;
    p = {ins[0], ad};
    host_u.start();
    host_u.xfer(1'b0, ins, junk);
    host_u.xfer(1'b0, ad, junk);
    repeat (n) begin
      host_u.xfer(1'b1, 8'h00, got);
      check({9'h0, got}, {9'h0, mem[p]});
      if (ins[7:4] == OP_RD_INC) p = p + 9'h1;
    end
    host_u.stop();
    check({16'h0, oe_n}, 17'h1);
  endtask
  initial begin
    for (int k = 0; k < 512; k++) mem[k] = 8'($random(seed));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    host_u.noise(4'h1);
    wr(8'h11, 8'hfd, 3);
    rd(8'h91, 8'hfd, 3);
    $display("test boundary done");
    for (int k = 0; k < 4; k++) begin
      a = 8'($random(seed)) & 8'h7f;
      wr({(k[0] ? OP_WR_FIX : OP_WR_INC), 4'(k)}, a, 3);
      rd({(k[1] ? OP_RD_FIX : OP_RD_INC), 4'(k)}, a, 2);
    end
    $display("test modes done");
    wr(8'h50, 8'h10, 2);
    wr(8'hd1, 8'h10, 2);
    host_u.start();
    host_u.xfer(1'b0, 8'h10, junk);
    host_u.xfer(1'b0, 8'h20, junk);
    host_u.nib(1'b0, 4'h5, junk[3:0]);
    host_u.stop();
    wr(8'h10, 8'h20, 1);
    $display("test refusal done");
    repeat (10) @(negedge clk);
    wrap_up();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    check(17'h0, 17'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
